// ===== intc_pkg.sv
// Package with the constants and types of the prioritised interrupt controller
package intc_pkg;

    // Source counts
    localparam int NUM_SRC = 24;
    localparam int NUM_PIN = 12;
    localparam int NUM_SEL_PIN = 8;
    localparam int NUM_DUAL_PIN = 4;
    localparam int NUM_PERIPH = 12;
    localparam int SRC_IDX_W = 5;

    // Register indices; the byte address is four times the index
    localparam int ADDR_W = 14;
    localparam logic [11:0] IDX_PIN_EN_HIGH = 12'hfc4;
    localparam logic [11:0] IDX_PIN_EN_LOW = 12'hfc5;
    localparam logic [11:0] IDX_PORT_SEL = 12'hfc6;
    localparam logic [11:0] IDX_EDGE_SEL = 12'hfc7;
    localparam logic [11:0] IDX_GRP2_EN_HIGH = 12'hfc8;
    localparam logic [11:0] IDX_GRP2_EN_LOW = 12'hfc9;
    localparam logic [11:0] IDX_PENDING = 12'hfca;
    localparam logic [11:0] IDX_STATUS = 12'hfcb;
    localparam logic [11:0] IDX_MASK = 12'hfcc;
    localparam logic [11:0] IDX_CONTROL = 12'hfcd;

    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [23:0] RST_SRC = 24'h000000;
    localparam logic [11:0] RST_PIN = 12'h000;

    // Control register fields
    localparam int CTRL_WDT_IRQ_BIT = 0;

    // Priority encoding of an enable bit pair
    localparam logic [1:0] PRIO_DISABLED = 2'h0;
    localparam logic [1:0] PRIO_LOW = 2'h1;
    localparam logic [1:0] PRIO_NOMINAL = 2'h2;
    localparam logic [1:0] PRIO_HIGH = 2'h3;

    // Vector table placement in program memory
    localparam logic [15:0] VECTOR_BASE = 16'h0008;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Request presented to the processor core
    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [SRC_IDX_W-1:0] index;
        logic [15:0] vec_addr_high;
        logic [15:0] vec_addr_low;
    } irq_req_type;

endpackage : intc_pkg

// ===== intc_edge_detect.sv
// Edge detection for the twelve pin interrupt sources
`timescale 1ns/100ps
module intc_edge_detect (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Pin levels and edge choice
    input wire logic [intc_pkg::NUM_PIN-1:0] pin_level_i,
    input wire logic [intc_pkg::NUM_SEL_PIN-1:0] falling_sel_i,
    // One-cycle edge events
    output logic [intc_pkg::NUM_PIN-1:0] pin_event_o
);

    logic armed_reg;
    logic [intc_pkg::NUM_PIN-1:0] prev_reg;
    logic [intc_pkg::NUM_PIN-1:0] event_next;

    // Per pin edge test; armed after a first sample
    genvar gi;
    generate
        for (gi = 0; gi < intc_pkg::NUM_PIN; gi++) begin : g_pin
            if (gi < intc_pkg::NUM_SEL_PIN) begin : g_sel
                assign event_next[gi] = armed_reg & (falling_sel_i[gi] ?
                    (prev_reg[gi] & ~pin_level_i[gi]) :
                    (~prev_reg[gi] & pin_level_i[gi]));
            end else begin : g_dual
                assign event_next[gi] = armed_reg &
                    (prev_reg[gi] ^ pin_level_i[gi]);
            end
        end
    endgenerate

    // Register previous levels and events
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed_reg <= 1'b0;
            prev_reg <= intc_pkg::RST_PIN;
            pin_event_o <= intc_pkg::RST_PIN;
        end else begin
            armed_reg <= 1'b1;
            prev_reg <= pin_level_i;
            pin_event_o <= event_next;
        end
    end

endmodule : intc_edge_detect

// ===== intc_priority_pick.sv
// Picks the winning pending source by level, then by source order
`timescale 1ns/100ps
module intc_priority_pick (
    // Pending requests and their levels
    input wire logic [intc_pkg::NUM_SRC-1:0] req_i,
    input wire logic [2*intc_pkg::NUM_SRC-1:0] level_i,
    // Winner
    output logic valid_o,
    output logic [1:0] level_o,
    output logic [intc_pkg::SRC_IDX_W-1:0] index_o
);

    // Scan downward so the lowest index wins a tie
    always_comb begin
        logic [1:0] lvl;
        lvl = intc_pkg::PRIO_DISABLED;
        valid_o = 1'b0;
        level_o = intc_pkg::PRIO_DISABLED;
        index_o = '0;
        for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            lvl = level_i[2*i +: 2];
            if (req_i[i] && lvl != intc_pkg::PRIO_DISABLED &&
                lvl >= level_o) begin
                valid_o = 1'b1;
                level_o = lvl;
                index_o = i[intc_pkg::SRC_IDX_W-1:0];
            end
        end
    end

endmodule : intc_priority_pick

// ===== prioritized_interrupt_controller.sv
// Prioritised vectored interrupt controller with AXI4-Lite registers
//
// Contract
// - 24 sources: 12 from port pins, 12 from on-chip peripherals.
// - Eight pin sources pick rising or falling edge; four fire on both.
// - Each source: three software priority levels or disabled.
// - Watchdog time-out may raise an interrupt, not only a reset.
// - Enabled request diverts the core to its routine, then it resumes.
// - Polled flags ignore priority and enable settings.
// - Vector high byte at even address, low byte at next odd.
// - Pin high enable byte at FC4H, read/write, zero on reset.
// - Pin low enable byte at FC5H, read/write, zero on reset.
// - Each pin bit from first or fourth port by select.
// - Pair: 00 off, 01 low, 10 nominal, 11 high.
`timescale 1ns/100ps
module prioritized_interrupt_controller (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // AXI4-Lite write channels
    input wire logic [intc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic [intc_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Interrupt sources
    input wire logic [7:0] port_first_i,
    input wire logic [7:0] port_fourth_i,
    input wire logic [intc_pkg::NUM_DUAL_PIN-1:0] dual_edge_pin_i,
    input wire logic [intc_pkg::NUM_PERIPH-2:0] periph_event_i,
    input wire logic wdt_timeout_i,
    // Processor core side
    output intc_pkg::irq_req_type core_req_o,
    input wire logic core_ack_i,
    // Reset request and polled interrupt line
    output logic wdt_reset_req_o,
    output logic irq_o
);

    // Configuration registers
    logic [7:0] pin_en_high_reg, pin_en_high_next;
    logic [7:0] pin_en_low_reg, pin_en_low_next;
    logic [7:0] port_sel_reg, port_sel_next;
    logic [7:0] edge_sel_reg, edge_sel_next;
    logic [15:0] grp2_en_high_reg, grp2_en_high_next;
    logic [15:0] grp2_en_low_reg, grp2_en_low_next;
    logic [23:0] mask_reg, mask_next;
    logic [7:0] control_reg, control_next;
    // Request state
    logic [23:0] pending_reg, pending_next;
    logic [23:0] status_reg, status_next;
    intc_pkg::irq_req_type core_req_next;
    logic wdt_reset_next, irq_next;
    // Bus state
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic [11:0] aw_idx_reg, aw_idx_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    // Internal wires
    logic [intc_pkg::NUM_PIN-1:0] pin_level;
    logic [intc_pkg::NUM_PIN-1:0] pin_event;
    logic [23:0] src_event;
    logic [47:0] src_level;
    logic do_write, do_read;
    logic [11:0] ar_idx;
    logic [23:0] ack_clr, sw_clr;
    logic pick_valid;
    logic [1:0] pick_level;
    logic [intc_pkg::SRC_IDX_W-1:0] pick_index;

    // Merge the held write data into a value by byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old_v);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (wstrb_reg[b]) begin
                res[8*b +: 8] = wdata_reg[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // Pin source selection between the two ports
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = port_sel_reg[i] ? port_fourth_i[i] :
                port_first_i[i];
        end
        pin_level[11:8] = dual_edge_pin_i;
    end

    // Pin edge detection
    intc_edge_detect u_edge (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pin_level_i(pin_level),
        .falling_sel_i(edge_sel_reg),
        .pin_event_o(pin_event)
    );

    // Event vector: pins, watchdog, then peripherals
    always_comb begin
        src_event = {periph_event_i,
            wdt_timeout_i & control_reg[intc_pkg::CTRL_WDT_IRQ_BIT],
            pin_event};
    end

    // Two-bit level per source
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            src_level[2*i +: 2] = {pin_en_high_reg[i],
                pin_en_low_reg[i]};
        end
        for (int i = 0; i < 16; i++) begin
            src_level[2*(i+8) +: 2] = {grp2_en_high_reg[i],
                grp2_en_low_reg[i]};
        end
    end

    // Bus handshake decode
    assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
    assign do_read = s_axi_arvalid_i && arready_reg;
    assign ar_idx = s_axi_araddr_i[intc_pkg::ADDR_W-1:2];

    // Write channel; AW and W in either order
    always_comb begin
        awready_next = awready_reg;
        wready_next = wready_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        aw_idx_next = aw_idx_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        if (s_axi_awvalid_i && awready_reg) begin
            awready_next = 1'b0;
            aw_idx_next = s_axi_awaddr_i[intc_pkg::ADDR_W-1:2];
        end
        if (s_axi_wvalid_i && wready_reg) begin
            wready_next = 1'b0;
            wdata_next = s_axi_wdata_i;
            wstrb_next = s_axi_wstrb_i;
        end
        if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            awready_next = 1'b1;
            wready_next = 1'b1;
            bvalid_next = 1'b1;
            if (aw_idx_reg >= intc_pkg::IDX_PIN_EN_HIGH &&
                aw_idx_reg <= intc_pkg::IDX_CONTROL) begin
                bresp_next = intc_pkg::RESP_OKAY;
            end else begin
                bresp_next = intc_pkg::RESP_SLVERR;
            end
        end
    end

    // Configuration register writes
    always_comb begin
        pin_en_high_next = pin_en_high_reg;
        pin_en_low_next = pin_en_low_reg;
        port_sel_next = port_sel_reg;
        edge_sel_next = edge_sel_reg;
        grp2_en_high_next = grp2_en_high_reg;
        grp2_en_low_next = grp2_en_low_reg;
        mask_next = mask_reg;
        control_next = control_reg;
        sw_clr = intc_pkg::RST_SRC;
        if (do_write) begin
            if (aw_idx_reg == intc_pkg::IDX_PIN_EN_HIGH) begin
                pin_en_high_next = 8'(merge(32'(pin_en_high_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_PIN_EN_LOW) begin
                pin_en_low_next = 8'(merge(32'(pin_en_low_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_PORT_SEL) begin
                port_sel_next = 8'(merge(32'(port_sel_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_EDGE_SEL) begin
                edge_sel_next = 8'(merge(32'(edge_sel_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_GRP2_EN_HIGH) begin
                grp2_en_high_next = 16'(merge(32'(grp2_en_high_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_GRP2_EN_LOW) begin
                grp2_en_low_next = 16'(merge(32'(grp2_en_low_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_PENDING) begin
                sw_clr = 24'(merge(32'h0));
            end else if (aw_idx_reg == intc_pkg::IDX_MASK) begin
                mask_next = 24'(merge(32'(mask_reg)));
            end else if (aw_idx_reg == intc_pkg::IDX_CONTROL) begin
                control_next = 8'(merge(32'(control_reg)));
            end
        end
    end

    // Read channel; data captured with the address
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        if (do_read) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = intc_pkg::RESP_OKAY;
            rdata_next = 32'h0;
            if (ar_idx == intc_pkg::IDX_PIN_EN_HIGH) begin
                rdata_next[7:0] = pin_en_high_reg;
            end else if (ar_idx == intc_pkg::IDX_PIN_EN_LOW) begin
                rdata_next[7:0] = pin_en_low_reg;
            end else if (ar_idx == intc_pkg::IDX_PORT_SEL) begin
                rdata_next[7:0] = port_sel_reg;
            end else if (ar_idx == intc_pkg::IDX_EDGE_SEL) begin
                rdata_next[7:0] = edge_sel_reg;
            end else if (ar_idx == intc_pkg::IDX_GRP2_EN_HIGH) begin
                rdata_next[15:0] = grp2_en_high_reg;
            end else if (ar_idx == intc_pkg::IDX_GRP2_EN_LOW) begin
                rdata_next[15:0] = grp2_en_low_reg;
            end else if (ar_idx == intc_pkg::IDX_PENDING) begin
                rdata_next[23:0] = pending_reg;
            end else if (ar_idx == intc_pkg::IDX_STATUS) begin
                rdata_next[23:0] = status_reg;
            end else if (ar_idx == intc_pkg::IDX_MASK) begin
                rdata_next[23:0] = mask_reg;
            end else if (ar_idx == intc_pkg::IDX_CONTROL) begin
                rdata_next[7:0] = control_reg;
            end else begin
                rresp_next = intc_pkg::RESP_SLVERR;
            end
        end
    end

    // Request flags; a new event always beats a clear in the same cycle
    always_comb begin
        ack_clr = intc_pkg::RST_SRC;
        if (core_ack_i && core_req_o.valid) begin
            ack_clr[core_req_o.index] = 1'b1;
        end
        pending_next = (pending_reg & ~(ack_clr | sw_clr)) | src_event;
        status_next = status_reg | src_event;
        if (do_read && ar_idx == intc_pkg::IDX_STATUS) begin
            status_next = src_event;
        end
    end

    // Pick from next pending so no stale winner shows
    intc_priority_pick u_pick (
        .req_i(pending_next),
        .level_i(src_level),
        .valid_o(pick_valid),
        .level_o(pick_level),
        .index_o(pick_index)
    );

    // Core request and polled line
    always_comb begin
        core_req_next.valid = pick_valid;
        core_req_next.level = pick_level;
        core_req_next.index = pick_index;
        core_req_next.vec_addr_high = intc_pkg::VECTOR_BASE +
            {10'h0, pick_index, 1'b0};
        core_req_next.vec_addr_low = intc_pkg::VECTOR_BASE +
            {10'h0, pick_index, 1'b1};
        irq_next = |(status_next & mask_next);
        wdt_reset_next = wdt_timeout_i &
            ~control_reg[intc_pkg::CTRL_WDT_IRQ_BIT];
    end

    // Register every state group
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_en_high_reg <= intc_pkg::RST_BYTE;
            pin_en_low_reg <= intc_pkg::RST_BYTE;
            port_sel_reg <= intc_pkg::RST_BYTE;
            edge_sel_reg <= intc_pkg::RST_BYTE;
            grp2_en_high_reg <= intc_pkg::RST_HALF;
            grp2_en_low_reg <= intc_pkg::RST_HALF;
            mask_reg <= intc_pkg::RST_SRC;
            control_reg <= intc_pkg::RST_BYTE;
            pending_reg <= intc_pkg::RST_SRC;
            status_reg <= intc_pkg::RST_SRC;
            core_req_o <= '0;
            irq_o <= 1'b0;
            wdt_reset_req_o <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= intc_pkg::RESP_OKAY;
            aw_idx_reg <= 12'h000;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= intc_pkg::RESP_OKAY;
        end else begin
            pin_en_high_reg <= pin_en_high_next;
            pin_en_low_reg <= pin_en_low_next;
            port_sel_reg <= port_sel_next;
            edge_sel_reg <= edge_sel_next;
            grp2_en_high_reg <= grp2_en_high_next;
            grp2_en_low_reg <= grp2_en_low_next;
            mask_reg <= mask_next;
            control_reg <= control_next;
            pending_reg <= pending_next;
            status_reg <= status_next;
            core_req_o <= core_req_next;
            irq_o <= irq_next;
            wdt_reset_req_o <= wdt_reset_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            aw_idx_reg <= aw_idx_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // Bus outputs from flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

endmodule : prioritized_interrupt_controller

// ===== prioritized_interrupt_controller_checker.sv
// Port-level checks for the prioritised interrupt controller
`timescale 1ns/100ps
module pic_checker (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Bus handshakes
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Core side and watchdog
    input wire intc_pkg::irq_req_type core_req_o,
    input wire logic core_ack_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_reset_req_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    // Vector pair follows the presented index
    vec_high_a: assert property (core_req_o.valid |->
        core_req_o.vec_addr_high == intc_pkg::VECTOR_BASE
        + {10'h000, core_req_o.index, 1'b0})
        else $error("vector high address wrong");
    vec_low_a: assert property (core_req_o.valid |->
        core_req_o.vec_addr_low == core_req_o.vec_addr_high + 16'h0001)
        else $error("vector low not odd");
    // Disabled sources are never presented
    level_on_a: assert property (core_req_o.valid |->
        core_req_o.level != intc_pkg::PRIO_DISABLED)
        else $error("disabled level presented");
    // Acknowledged index leaves the core request
    ack_clear_a: assert property (core_ack_i && core_req_o.valid |=>
        !(core_req_o.valid && core_req_o.index == $past(core_req_o.index)))
        else $error("acked request kept");
    // Reset request only follows a time-out
    wdt_reset_a: assert property (wdt_reset_req_o |->
        $past(wdt_timeout_i)) else $error("reset without time-out");
    // Register bus answers and holds
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o) else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    rd_busy_a: assert property (s_axi_rvalid_o |->
        !s_axi_arready_o) else $error("address taken while answering");
    wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o)
        else $error("write response late");
endmodule : pic_checker

bind prioritized_interrupt_controller pic_checker u_chk (.*);

// ===== pic_core_model.sv
// Behavioural processor core that services presented requests
`timescale 1ns/100ps
module pic_core_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Presented request and pacing
    input wire intc_pkg::irq_req_type core_req_i,
    input wire logic enable_i,
    input wire logic [3:0] delay_i,
    // Service acknowledge
    output logic core_ack_o
);
    logic [3:0] wait_reg;

    // Serve delay_i cycles, then acknowledge
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_ack_o <= 1'b0;
            wait_reg <= 4'h0;
        end else if (core_ack_o || !enable_i || !core_req_i.valid) begin
            core_ack_o <= 1'b0; // Gap lets the next winner settle
            wait_reg <= 4'h0;
        end else if (wait_reg >= delay_i) begin
            core_ack_o <= 1'b1;
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : pic_core_model

// ===== prioritized_interrupt_controller_tb.sv
// Self-checking bench for the prioritised interrupt controller
`timescale 1ns/100ps
module prioritized_interrupt_controller_tb;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [13:0] s_axi_awaddr_i = 14'h0000, s_axi_araddr_i = 14'h0000;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0, wdt_timeout_i = 1'b0, core_en = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, core_ack_i, wdt_reset_req_o, irq_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic [7:0] port_first_i = 8'h04, port_fourth_i = 8'h00;
    logic [3:0] dual_edge_pin_i = 4'h0, delay = 4'h0;
    logic [10:0] periph_event_i = 11'h000;
    intc_pkg::irq_req_type core_req_o;
    int num_errors = 0, n_tests = 0;
    int order[5] = '{14, 12, 15, 16, 13};
    logic [4:0] served[$];

    always #10 clk_sys_i = ~clk_sys_i;

    prioritized_interrupt_controller DUT (.*);
    pic_core_model u_core (.clk_sys_i, .nrst_i, .core_req_i(core_req_o),
        .enable_i(core_en), .delay_i(delay), .core_ack_o(core_ack_i));

    // Serviced indices
    always @(posedge clk_sys_i) begin
        if (core_ack_i === 1'b1 && core_req_o.valid === 1'b1) begin
            served.push_back(core_req_o.index);
        end
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // AW and W offered together
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        s_axi_awaddr_i <= {idx, 2'b00};
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        check("bresp", {30'h0, s_axi_bresp_o}, 32'h0);
        s_axi_bready_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr

    task automatic rd_reg(input logic [11:0] idx, output logic [31:0] d,
                          output logic [1:0] r);
        s_axi_araddr_i <= {idx, 2'b00};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : rd_reg

    task automatic rchk(input logic [11:0] idx, input logic [31:0] exp,
                        input logic [1:0] exp_r, input string name);
        logic [31:0] d;
        logic [1:0] r;
        rd_reg(idx, d, r);
        check(name, d, exp);
        check("read response", {30'h0, r}, {30'h0, exp_r});
    endtask : rchk

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        // Enable bytes and an unmapped place
        rchk(intc_pkg::IDX_PIN_EN_HIGH, 32'h0, 2'h0, "enable high");
        rchk(intc_pkg::IDX_PIN_EN_LOW, 32'h0, 2'h0, "enable low");
        wr(intc_pkg::IDX_PIN_EN_HIGH, 32'h000000a5);
        rchk(intc_pkg::IDX_PIN_EN_HIGH, 32'ha5, 2'h0, "enable high");
        wr(intc_pkg::IDX_PIN_EN_LOW, 32'h0000005a);
        rchk(intc_pkg::IDX_PIN_EN_LOW, 32'h5a, 2'h0, "enable low");
        rchk(12'h000, 32'h0, intc_pkg::RESP_SLVERR, "unmapped");
        // Pin 1 from fourth port, pin 2 falling
        wr(intc_pkg::IDX_PIN_EN_HIGH, 32'h01);
        wr(intc_pkg::IDX_PIN_EN_LOW, 32'h01);
        wr(intc_pkg::IDX_PORT_SEL, 32'h02);
        wr(intc_pkg::IDX_EDGE_SEL, 32'h04);
        core_en <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rd_reg(intc_pkg::IDX_STATUS, rd, rsp);
        port_first_i <= 8'h07;
        port_fourth_i <= 8'h02;
        dual_edge_pin_i <= 4'h1;
        repeat (4) @(posedge clk_sys_i);
        rchk(intc_pkg::IDX_STATUS, 32'h103, 2'h0, "rising");
        port_first_i <= 8'h00;
        dual_edge_pin_i <= 4'h0;
        repeat (4) @(posedge clk_sys_i);
        rchk(intc_pkg::IDX_STATUS, 32'h104, 2'h0, "falling");
        check("pin served", served.size(), 1);
        check("pin index", {27'h0, served[0]}, 32'h0);
        served.delete();
        // Watchdog in reset mode
        wdt_timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        wdt_timeout_i <= 1'b0;
        #1 check("wdt reset", {31'h0, wdt_reset_req_o}, 32'h1);
        @(posedge clk_sys_i);
        // Six events at once, five of them enabled, core stalled
        core_en <= 1'b0;
        delay <= 4'h3;
        wr(intc_pkg::IDX_CONTROL, 32'h1);
        wr(intc_pkg::IDX_GRP2_EN_HIGH, 32'h01d0);
        wr(intc_pkg::IDX_GRP2_EN_LOW, 32'h0060);
        wr(intc_pkg::IDX_MASK, 32'h020000);
        rd_reg(intc_pkg::IDX_STATUS, rd, rsp);
        periph_event_i <= 11'h01f;
        wdt_timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        periph_event_i <= 11'h000;
        wdt_timeout_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check("winner", {27'h0, core_req_o.index}, 32'd14);
        check("level", {30'h0, core_req_o.level}, 32'd3);
        check("vec high", {16'h0, core_req_o.vec_addr_high}, 32'h24);
        check("vec low", {16'h0, core_req_o.vec_addr_low}, 32'h25);
        check("no reset", {31'h0, wdt_reset_req_o}, 32'h0);
        check("irq", {31'h0, irq_o}, 32'h1);
        rchk(intc_pkg::IDX_STATUS, 32'h03f000, 2'h0, "status");
        repeat (2) @(posedge clk_sys_i);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        core_en <= 1'b1;
        repeat (60) @(posedge clk_sys_i);
        check("served", served.size(), 5);
        foreach (order[i]) check("order", {27'h0, served[i]}, order[i]);
        check("idle", {31'h0, core_req_o.valid}, 32'h0);
        report_and_stop();
    end
endmodule : prioritized_interrupt_controller_tb
